// *** core/rssc_counter.sv ***
`timescale 1ns/1ps
`default_nettype none

// Down counter that loads a length and reports when it has run out.
module rssc_counter (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [15:0] length,
  output logic done
);

  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic done_ff;
  logic nxt_done;

  // A load restarts the count; done holds once reached.
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_done = done_ff;
    if (load) begin
      nxt_cnt = length;
      nxt_done = (length == 16'h0000);
    end else if (cnt_ff != 16'h0000) begin
      nxt_cnt = cnt_ff - 16'h0001;
      nxt_done = (cnt_ff == 16'h0001);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= 16'h0000;
      done_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign done = done_ff;

endmodule

`default_nettype wire

// *** core/rssc_ctrl.sv ***
// Operation
// - Reset instruction resets the device and clears its flag.
// - Stack reset enabled: overflow or underflow resets and sets its flag.
// - Leaving programming mode repeats the power-on start-up sequence.
// - Power-up timer runs after power-on or brown-out only when enabled.
// - Execution waits for power-up timer, oscillator timer and pin release.
// - Both start-up timers count while the reset pin is still low.
// - Execution starts 10 oscillator cycles after the pin rises, timers done.
// - Enabled and flagged interrupt wakes the device even with global off.
// - Pending interrupt before sleep makes sleep a no-operation.
// - Wake in sleep clears watchdog, sets timeout, clears power-down.
// - Peripheral interrupts need the peripheral interrupt enable bit set.
// - Watchdog expiry without clear resets and updates status flags.
// - Pin held low keeps the device in reset; device never drives it.
`timescale 1ns/1ps
`default_nettype none

module rssc_ctrl (
  input wire logic mclk,
  input wire logic nrst,
  input wire rssc_pkg::rssc_cause_s cause,
  input wire logic ext_reset_pin_n,
  input wire logic ext_reset_enable,
  input wire logic stack_reset_enable,
  input wire logic powerup_timer_enable_n,
  input wire logic osc_needs_ost,
  input wire logic [1:0] watchdog_config_mode,
  input wire logic watchdog_clear_instruction,
  input wire logic sleep_instruction,
  input wire logic core_int_pending,
  input wire logic [7:0] periph_int_flags,
  input wire logic [7:0] periph_int_enables,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic core_run,
  output logic core_asleep,
  output logic wake_event,
  output logic watchdog_reset
);

  // ---------------------------------------------------------------
  // Pin synchroniser and noise filter
  // ---------------------------------------------------------------
  logic pin_s1_ff, pin_s2_ff, pin_low_ff, nxt_pin_low;
  logic [rssc_pkg::FILT_BITS-1:0] filt_ff, nxt_filt;

  // A pin level must hold for the whole filter window to be believed.
  always_comb begin
    nxt_filt = {filt_ff[rssc_pkg::FILT_BITS-2:0], pin_s2_ff};
    nxt_pin_low = pin_low_ff;
    if (nxt_filt == '0) begin
      nxt_pin_low = ext_reset_enable;
    end else if (&nxt_filt || !ext_reset_enable) begin
      nxt_pin_low = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pin_s1_ff <= 1'b1;
      pin_s2_ff <= 1'b1;
      filt_ff <= '1;
      pin_low_ff <= 1'b0;
    end else begin
      pin_s1_ff <= ext_reset_pin_n;
      pin_s2_ff <= pin_s1_ff;
      filt_ff <= nxt_filt;
      pin_low_ff <= nxt_pin_low;
    end
  end

  // ---------------------------------------------------------------
  // Registers and wake detection
  // ---------------------------------------------------------------
  logic [7:0] wdog_ctrl_ff, nxt_wdog_ctrl, pwr_ctrl_ff, nxt_pwr_ctrl;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [1:0] int_ctrl_ff, nxt_int_ctrl;
  logic timeout_flag_ff, nxt_timeout_flag;
  logic powerdown_flag_ff, nxt_powerdown_flag;
  logic wake_src, stack_rst, seq_rst, full_rst, wdt_fire;
  rssc_pkg::rssc_seq_e state_ff, nxt_state;

  // Wake ignores the global enable; peripherals also need their gate.
  assign wake_src = core_int_pending
    | (int_ctrl_ff[0] & |(periph_int_flags & periph_int_enables));
  assign stack_rst = stack_reset_enable & (cause.stk_ovf | cause.stk_unf);
  // Cause resets reload the timers; a low pin holds the sequencer but leaves the timers running.
  assign seq_rst = cause.por | cause.bor | cause.prog_exit
    | cause.reset_instr | stack_rst | wdt_fire;
  assign full_rst = seq_rst | pin_low_ff;

  // Register writes, cause flags and sleep status bookkeeping.
  always_comb begin
    nxt_wdog_ctrl = wdog_ctrl_ff;
    nxt_pwr_ctrl = pwr_ctrl_ff;
    nxt_int_ctrl = int_ctrl_ff;
    nxt_timeout_flag = timeout_flag_ff;
    nxt_powerdown_flag = powerdown_flag_ff;
    nxt_rdata = 8'h00;
    if (reg_wr) begin
      case (reg_addr)
        rssc_pkg::ADDR_WDOG_CTRL: nxt_wdog_ctrl = {2'h0, reg_wdata[5:0]};
        rssc_pkg::ADDR_PWR_CTRL: nxt_pwr_ctrl = reg_wdata;
        rssc_pkg::ADDR_INT_CTRL: nxt_int_ctrl = reg_wdata[7:6];
        default: nxt_rdata = 8'h00;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        rssc_pkg::ADDR_WDOG_CTRL: nxt_rdata = wdog_ctrl_ff;
        rssc_pkg::ADDR_PWR_CTRL: nxt_rdata = pwr_ctrl_ff;
        rssc_pkg::ADDR_STATUS:
          nxt_rdata = {6'h00, timeout_flag_ff, powerdown_flag_ff};
        rssc_pkg::ADDR_INT_CTRL: nxt_rdata = {int_ctrl_ff, 6'h00};
        default: nxt_rdata = 8'h00;
      endcase
    end
    // Hardware events are applied after writes so that they win.
    if (cause.por | cause.prog_exit) begin
      nxt_pwr_ctrl = rssc_pkg::PWR_CTRL_POR_VAL;
      nxt_pwr_ctrl[rssc_pkg::PC_POR_BIT] = 1'b0;
      nxt_wdog_ctrl = rssc_pkg::WDOG_CTRL_RST;
      nxt_timeout_flag = 1'b1;
      nxt_powerdown_flag = 1'b1;
    end
    if (cause.bor) begin
      nxt_pwr_ctrl[rssc_pkg::PC_BOR_BIT] = 1'b0;
    end
    if (cause.reset_instr) begin
      nxt_pwr_ctrl[rssc_pkg::PC_RI_BIT] = 1'b0;
    end
    if (stack_reset_enable & cause.stk_ovf) begin
      nxt_pwr_ctrl[rssc_pkg::PC_OVF_BIT] = 1'b1;
    end
    if (stack_reset_enable & cause.stk_unf) begin
      nxt_pwr_ctrl[rssc_pkg::PC_UNF_BIT] = 1'b1;
    end
    if (pin_low_ff) begin
      nxt_pwr_ctrl[rssc_pkg::PC_EXTERNAL_RESET_PIN_BIT] = 1'b0;
    end
    if (wdt_fire) begin
      nxt_pwr_ctrl[rssc_pkg::PC_WDT_BIT] = 1'b0;
      nxt_timeout_flag = 1'b0;
      nxt_powerdown_flag = (state_ff != rssc_pkg::SEQ_SLEEP);
    end
    if (watchdog_clear_instruction && state_ff == rssc_pkg::SEQ_RUN) begin
      nxt_timeout_flag = 1'b1;
      nxt_powerdown_flag = 1'b1;
    end
    // A sleep with a wake source already pending changes nothing.
    if (sleep_instruction && state_ff == rssc_pkg::SEQ_RUN
        && !wake_src) begin
      nxt_timeout_flag = 1'b1;
      nxt_powerdown_flag = 1'b0;
    end
    if (state_ff == rssc_pkg::SEQ_SLEEP && wake_src) begin
      nxt_timeout_flag = 1'b1;
      nxt_powerdown_flag = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wdog_ctrl_ff <= rssc_pkg::WDOG_CTRL_RST;
      pwr_ctrl_ff <= rssc_pkg::PWR_CTRL_POR_VAL;
      int_ctrl_ff <= 2'h0;
      timeout_flag_ff <= 1'b1;
      powerdown_flag_ff <= 1'b1;
      rdata_ff <= 8'h00;
    end else begin
      wdog_ctrl_ff <= nxt_wdog_ctrl;
      pwr_ctrl_ff <= nxt_pwr_ctrl;
      int_ctrl_ff <= nxt_int_ctrl;
      timeout_flag_ff <= nxt_timeout_flag;
      powerdown_flag_ff <= nxt_powerdown_flag;
      rdata_ff <= nxt_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Start-up sequencer
  // ---------------------------------------------------------------
  logic dly_done, pwrt_done, ost_done;
  logic pwrt_skip_ff, nxt_pwrt_skip, ost_skip_ff, nxt_ost_skip;
  logic wake_ff, nxt_wake, asleep_ff, run_ff;
  // Timers restart on cause resets only and run on under a held pin.
  rssc_counter u_pwrt (
    .mclk(mclk),
    .nrst(nrst),
    .load(seq_rst),
    .length(16'(rssc_pkg::PWRT_CYC)),
    .done(pwrt_done)
  );
  rssc_counter u_ost (
    .mclk(mclk),
    .nrst(nrst),
    .load(seq_rst),
    .length(16'(rssc_pkg::OST_CYC)),
    .done(ost_done)
  );
  // The fixed delay reloads until the pin stage is entered.
  rssc_counter u_dly (
    .mclk(mclk),
    .nrst(nrst),
    .load(state_ff != rssc_pkg::SEQ_PIN),
    .length(16'(rssc_pkg::PIN_DELAY_CYC)),
    .done(dly_done)
  );

  // Power-up timer is skipped unless a power-on class reset asked for it.
  always_comb begin
    nxt_pwrt_skip = pwrt_skip_ff;
    nxt_ost_skip = ost_skip_ff;
    if (seq_rst) begin
      nxt_pwrt_skip = !((cause.por | cause.bor | cause.prog_exit)
        & !powerup_timer_enable_n);
      nxt_ost_skip = !osc_needs_ost;
    end
  end

  // The pin stage is entered only once both timers are finished or skipped, which
  // lets the timers expire under a held pin and gives the fixed delay.
  always_comb begin
    nxt_state = state_ff;
    nxt_wake = 1'b0;
    case (state_ff)
      rssc_pkg::SEQ_HOLD: begin
        if (!full_rst) begin
          nxt_state = rssc_pkg::SEQ_TIMERS;
        end
      end
      rssc_pkg::SEQ_TIMERS: begin
        if ((pwrt_done | pwrt_skip_ff) && (ost_done | ost_skip_ff)
            && !pin_low_ff) begin
          nxt_state = rssc_pkg::SEQ_PIN;
        end
      end
      rssc_pkg::SEQ_PIN: begin
        if (dly_done) begin
          nxt_state = rssc_pkg::SEQ_RUN;
        end
      end
      rssc_pkg::SEQ_RUN: begin
        if (sleep_instruction && !wake_src) begin
          nxt_state = rssc_pkg::SEQ_SLEEP;
        end
      end
      rssc_pkg::SEQ_SLEEP: begin
        if (wake_src) begin
          nxt_state = rssc_pkg::SEQ_RUN;
          nxt_wake = 1'b1;
        end
      end
      default: nxt_state = rssc_pkg::SEQ_HOLD;
    endcase
    if (full_rst) begin
      nxt_state = rssc_pkg::SEQ_HOLD;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= rssc_pkg::SEQ_HOLD;
      pwrt_skip_ff <= 1'b0;
      ost_skip_ff <= 1'b0;
      wake_ff <= 1'b0;
      asleep_ff <= 1'b0;
      run_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pwrt_skip_ff <= nxt_pwrt_skip;
      ost_skip_ff <= nxt_ost_skip;
      wake_ff <= nxt_wake;
      asleep_ff <= (nxt_state == rssc_pkg::SEQ_SLEEP);
      run_ff <= (nxt_state == rssc_pkg::SEQ_RUN);
    end
  end

  // ---------------------------------------------------------------
  // Watchdog prescaler
  // ---------------------------------------------------------------
  logic [23:0] wdt_cnt_ff, nxt_wdt_cnt, wdt_limit;
  logic [4:0] ps_code, ps_eff;
  logic wdt_on, wdt_fire_ff;

  assign ps_code = wdog_ctrl_ff[rssc_pkg::WDOG_PS_LSB +: 5];
  // Reserved codes above the top ratio fall back to the shortest one.
  assign ps_eff = (ps_code > rssc_pkg::WDOG_PS_MAX)
    ? rssc_pkg::WDOG_PS_MIN : ps_code;
  assign wdt_limit = 24'h000001
    << (ps_eff + 5'(rssc_pkg::WDOG_BASE_BITS));
  // Soft enable counts only in the software mode; other modes fix it.
  assign wdt_on = (watchdog_config_mode == rssc_pkg::WCFG_SOFT)
    ? wdog_ctrl_ff[rssc_pkg::WDOG_EN_BIT]
    : (watchdog_config_mode != rssc_pkg::WCFG_OFF);
  assign wdt_fire = wdt_fire_ff;

  // Cleared by any reset, by the clear instruction, by sleep entry and
  // on wake; not by a sleep that collapses to a no-operation.
  always_comb begin
    nxt_wdt_cnt = wdt_cnt_ff + 24'h000001;
    if (full_rst || !wdt_on || watchdog_clear_instruction
        || state_ff == rssc_pkg::SEQ_HOLD
        || (sleep_instruction && !wake_src)
        || (state_ff == rssc_pkg::SEQ_SLEEP && wake_src)) begin
      nxt_wdt_cnt = 24'h000000;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wdt_cnt_ff <= 24'h000000;
      wdt_fire_ff <= 1'b0;
    end else begin
      wdt_cnt_ff <= nxt_wdt_cnt;
      wdt_fire_ff <= (nxt_wdt_cnt == wdt_limit - 24'h000001);
    end
  end

  assign reg_rdata = rdata_ff;
  assign core_run = run_ff;
  assign core_asleep = asleep_ff;
  assign wake_event = wake_ff;
  assign watchdog_reset = wdt_fire_ff;

endmodule

`default_nettype wire

// *** core/rssc_pkg.sv ***
package rssc_pkg;

  // Register indices on the plain register port.
  localparam logic [1:0] ADDR_WDOG_CTRL = 2'h0;
  localparam logic [1:0] ADDR_PWR_CTRL = 2'h1;
  localparam logic [1:0] ADDR_STATUS = 2'h2;
  localparam logic [1:0] ADDR_INT_CTRL = 2'h3;

  // Watchdog control fields and reset value (period code 01011, off).
  localparam int WDOG_PS_LSB = 1;
  localparam int WDOG_EN_BIT = 0;
  localparam logic [7:0] WDOG_CTRL_RST = 8'h16;
  localparam logic [4:0] WDOG_PS_MAX = 5'h12;
  localparam logic [4:0] WDOG_PS_MIN = 5'h00;
  localparam int WDOG_BASE_BITS = 5;

  // Power control register bit positions.
  localparam int PC_OVF_BIT = 7;
  localparam int PC_UNF_BIT = 6;
  localparam int PC_WDT_BIT = 4;
  localparam int PC_EXTERNAL_RESET_PIN_BIT = 3;
  localparam int PC_RI_BIT = 2;
  localparam int PC_POR_BIT = 1;
  localparam int PC_BOR_BIT = 0;
  localparam logic [7:0] PWR_CTRL_POR_VAL = 8'h1C;

  // Status bits and interrupt control bits.
  localparam int ST_TO_BIT = 1;
  localparam int ST_PD_BIT = 0;
  localparam int IC_GIE_BIT = 7;
  localparam int IC_PERIPHERAL_INT_ENABLE_BIT = 6;

  // Watchdog configuration modes.
  localparam logic [1:0] WCFG_OFF = 2'h0;
  localparam logic [1:0] WCFG_SOFT = 2'h1;

  // Start-up timing, in oscillator cycles at 100 MHz.
  localparam int CLK_NS = 10;
  localparam int PWRT_NS = 640;
  localparam int OST_NS = 10240;
  localparam int PWRT_CYC = (PWRT_NS + CLK_NS - 1) / CLK_NS;
  localparam int OST_CYC = (OST_NS + CLK_NS - 1) / CLK_NS;
  localparam int PIN_DELAY_CYC = 10;
  localparam int FILT_BITS = 2;

  typedef enum logic [2:0] {
    SEQ_HOLD = 3'b000,
    SEQ_TIMERS = 3'b001,
    SEQ_PIN = 3'b010,
    SEQ_RUN = 3'b011,
    SEQ_SLEEP = 3'b100
  } rssc_seq_e;

  // Reset causes raised by the core or supply monitors.
  typedef struct packed {
    logic por;
    logic bor;
    logic prog_exit;
    logic reset_instr;
    logic stk_ovf;
    logic stk_unf;
  } rssc_cause_s;

endpackage

// *** testbench/rssc_ctrl_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Port checker for the reset sequencer
// ----------------------------------------
module rssc_ctrl_chk (
  input wire logic mclk,
  input wire logic nrst,
  input wire rssc_pkg::rssc_cause_s cause,
  input wire logic ext_reset_pin_n,
  input wire logic ext_reset_enable,
  input wire logic stack_reset_enable,
  input wire logic sleep_instruction,
  input wire logic core_int_pending,
  input wire logic core_run,
  input wire logic core_asleep,
  input wire logic wake_event,
  input wire logic watchdog_reset
);
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // Execution may only start once the pin has been high long enough.
  run_delay_a: assert property (
    $rose(core_run) && ext_reset_enable |-> $past(ext_reset_pin_n, 10))
    else $error("core started too soon after the pin rose");
  instr_reset_a: assert property (
    cause.reset_instr |-> ##[1:2] !core_run)
    else $error("reset instruction did not stop the core");
  stack_reset_a: assert property (
    stack_reset_enable && (cause.stk_ovf || cause.stk_unf)
    |-> ##[1:2] !core_run)
    else $error("stack fault did not stop the core");
  wdog_reset_a: assert property (
    watchdog_reset |-> ##[0:2] !core_run)
    else $error("watchdog expiry did not stop the core");
  pin_hold_a: assert property (
    (ext_reset_enable && !ext_reset_pin_n) [*8] |=> !core_run)
    else $error("core ran with the reset pin held low");
  sleep_nop_a: assert property (
    sleep_instruction && core_run && core_int_pending |=> !core_asleep)
    else $error("sleep taken with a wake source pending");
  sleep_entry_a: assert property (
    sleep_instruction && core_run && !core_int_pending |=> core_asleep)
    else $error("sleep not entered");
  wake_up_a: assert property (
    core_asleep && core_int_pending |-> ##[1:3] !core_asleep)
    else $error("pending source did not wake the core");
  wake_pulse_a: assert property (
    wake_event |=> !wake_event)
    else $error("wake pulse longer than one cycle");

  // Main scenarios that the bench must reach.
  cover property ($rose(core_run));
  cover property (wake_event);
  cover property (watchdog_reset);
endmodule

bind rssc_ctrl rssc_ctrl_chk u_rssc_ctrl_chk (
  .mclk(mclk),
  .nrst(nrst),
  .cause(cause),
  .ext_reset_pin_n(ext_reset_pin_n),
  .ext_reset_enable(ext_reset_enable),
  .stack_reset_enable(stack_reset_enable),
  .sleep_instruction(sleep_instruction),
  .core_int_pending(core_int_pending),
  .core_run(core_run),
  .core_asleep(core_asleep),
  .wake_event(wake_event),
  .watchdog_reset(watchdog_reset)
);

`default_nettype wire

// *** testbench/rssc_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// External reset pin driver
// ----------------------------------------
module rssc_pin_model (
  input wire logic hold_low,
  output wire logic ext_reset_pin_n
);
  // Plain driven level, no pull-up: a released pin reads high, a held pin low.
  assign ext_reset_pin_n = hold_low ? 1'b0 : 1'b1;
endmodule

`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  rssc_pkg::rssc_cause_s cause = '0;
  logic pin_hold = 1'b1;
  wire ext_reset_pin_n;
  logic ext_reset_enable = 1'b1;
  logic stack_reset_enable = 1'b0;
  logic powerup_timer_enable_n = 1'b0;
  logic osc_needs_ost = 1'b1;
  logic [1:0] watchdog_config_mode = 2'h0;
  logic watchdog_clear_instruction = 1'b0;
  logic sleep_instruction = 1'b0;
  logic core_int_pending = 1'b0;
  logic [7:0] periph_int_flags = 8'h00;
  logic [7:0] periph_int_enables = 8'h00;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata, v, s;
  logic core_run, core_asleep, wake_event, watchdog_reset;
  int miscompares = 0;
  int n_tests = 0;
  int n;
  // Watchdog cases: period code, soft enable, mode, expected cycles.
  logic [4:0] codes [5] = '{5'h00, 5'h01, 5'h02, 5'h13, 5'h1F};
  logic ens [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  logic [1:0] modes [5] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h2};
  int lens [5] = '{32, 64, 128, 32, 32};

  rssc_ctrl u_rssc_ctrl (
    .mclk(mclk),
    .nrst(nrst),
    .cause(cause),
    .ext_reset_pin_n(ext_reset_pin_n),
    .ext_reset_enable(ext_reset_enable),
    .stack_reset_enable(stack_reset_enable),
    .powerup_timer_enable_n(powerup_timer_enable_n),
    .osc_needs_ost(osc_needs_ost),
    .watchdog_config_mode(watchdog_config_mode),
    .watchdog_clear_instruction(watchdog_clear_instruction),
    .sleep_instruction(sleep_instruction),
    .core_int_pending(core_int_pending),
    .periph_int_flags(periph_int_flags),
    .periph_int_enables(periph_int_enables),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .core_run(core_run),
    .core_asleep(core_asleep),
    .wake_event(wake_event),
    .watchdog_reset(watchdog_reset)
  );
  rssc_pin_model u_rssc_pin_model (
    .hold_low(pin_hold),
    .ext_reset_pin_n(ext_reset_pin_n)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Tasks end 1 ns past an edge so outputs are settled when read.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic pulse(input logic [5:0] c);
    cause <= rssc_pkg::rssc_cause_s'(c);
    @(posedge mclk);
    cause <= '0;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task automatic go_sleep;
    sleep_instruction <= 1'b1;
    @(posedge mclk);
    sleep_instruction <= 1'b0;
    @(posedge mclk);
    #1;
  endtask
  function automatic logic seen(input int k);
    case (k)
      0: seen = core_run;
      1: seen = watchdog_reset;
      default: seen = !core_asleep;
    endcase
  endfunction
  // Bounded wait; n reaches lim when the event never came.
  task automatic wait_for(input int k, input int lim, output int n);
    n = 0;
    while (seen(k) !== 1'b1 && n < lim) begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask
  task automatic final_report;
    $display("tests=%0d miscompares=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------
  initial begin
    forever #5 mclk = ~mclk;
  end
  // Longest path is about ten start-ups of some 1100 cycles each.
  initial begin
    repeat (30000) @(posedge mclk);
    miscompares++;
    final_report;
  end
  initial begin
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    #1;
    // Timers must expire while the pin is still held low.
    pulse(6'h20);
    repeat (1100) @(posedge mclk);
    chk({7'h00, core_run}, 8'h00);
    pin_hold <= 1'b0;
    wait_for(0, 3000, n);
    chk({7'h00, n >= 10 && n <= 20}, 8'h01);
    rd(rssc_pkg::ADDR_PWR_CTRL, v);
    // The pin was held low across power-on, so its flag reads cleared.
    chk(v, rssc_pkg::PWR_CTRL_POR_VAL & 8'hF7);
    rd(rssc_pkg::ADDR_WDOG_CTRL, v);
    chk(v, rssc_pkg::WDOG_CTRL_RST);
    // Soft mode with the enable bit clear keeps the watchdog quiet.
    watchdog_config_mode <= rssc_pkg::WCFG_SOFT;
    wr(rssc_pkg::ADDR_WDOG_CTRL, 8'h00);
    wait_for(1, 100, n);
    chk({7'h00, n == 100}, 8'h01);
    for (int i = 0; i < 5; i++) begin
      watchdog_config_mode <= modes[i];
      wr(rssc_pkg::ADDR_WDOG_CTRL, {2'b00, codes[i], ens[i]});
      rd(rssc_pkg::ADDR_WDOG_CTRL, v);
      chk(v, {2'b00, codes[i], ens[i]});
      watchdog_clear_instruction <= 1'b1;
      @(posedge mclk);
      watchdog_clear_instruction <= 1'b0;
      #1;
      wait_for(1, 400, n);
      chk({7'h00, n >= lens[i] - 2 && n <= lens[i] + 3}, 8'h01);
      watchdog_config_mode <= rssc_pkg::WCFG_OFF;
      // Let the expiry take the core down before waiting for the restart.
      @(posedge mclk);
      #1;
      wait_for(0, 3000, n);
      rd(rssc_pkg::ADDR_STATUS, v);
      chk(v, 8'h01);
    end
    pulse(6'h04);
    wait_for(0, 3000, n);
    rd(rssc_pkg::ADDR_PWR_CTRL, v);
    chk(v & 8'h04, 8'h00);
    // Stack faults reset only while the stack reset is enabled.
    for (int i = 0; i < 4; i++) begin
      stack_reset_enable <= (i < 2);
      wr(rssc_pkg::ADDR_PWR_CTRL, 8'h1C);
      pulse(i[0] ? 6'h01 : 6'h02);
      chk({7'h00, core_run}, {7'h00, i >= 2});
      wait_for(0, 3000, n);
      rd(rssc_pkg::ADDR_PWR_CTRL, v);
      chk(v & 8'hC0, i < 2 ? (i[0] ? 8'h40 : 8'h80) : 8'h00);
    end
    // Programming exit with both timers; brown-out with no timer, then power-up timer only.
    for (int i = 0; i < 3; i++) begin
      osc_needs_ost <= (i == 0);
      powerup_timer_enable_n <= (i == 1);
      pulse(i == 0 ? 6'h08 : 6'h10);
      wait_for(0, 3000, n);
      if (i == 0) chk({7'h00, n >= rssc_pkg::OST_CYC - 8}, 8'h01);
      if (i == 1) chk({7'h00, n < 40}, 8'h01);
      if (i == 2) chk({7'h00, n >= rssc_pkg::PWRT_CYC - 8}, 8'h01);
    end
    // Sleep with a pending source is a no-operation.
    wr(rssc_pkg::ADDR_INT_CTRL, 8'h00);
    rd(rssc_pkg::ADDR_STATUS, s);
    core_int_pending <= 1'b1;
    go_sleep;
    chk({7'h00, core_asleep}, 8'h00);
    rd(rssc_pkg::ADDR_STATUS, v);
    chk(v, s);
    core_int_pending <= 1'b0;
    go_sleep;
    chk({7'h00, core_asleep}, 8'h01);
    core_int_pending <= 1'b1;
    wait_for(2, 10, n);
    chk({7'h00, n <= 3}, 8'h01);
    rd(rssc_pkg::ADDR_STATUS, v);
    chk(v, 8'h02);
    // Peripheral source wakes only once its group enable is set.
    core_int_pending <= 1'b0;
    periph_int_flags <= 8'h01;
    periph_int_enables <= 8'h01;
    go_sleep;
    wait_for(2, 8, n);
    chk({7'h00, core_asleep}, 8'h01);
    wr(rssc_pkg::ADDR_INT_CTRL, 8'h40);
    wait_for(2, 8, n);
    chk({7'h00, core_asleep}, 8'h00);
    // With the pin function off, a low pin must not reset the core.
    ext_reset_enable <= 1'b0;
    pin_hold <= 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    chk({7'h00, core_run}, 8'h01);
    final_report;
  end
endmodule

`default_nettype wire
